// file: unlock_seek_pkg.sv
// Shared constants for the unlock and seek task-file block.
// Assumes one 20 MHz clock shared by both ends.
package unlock_seek_pkg;

   // *****************************************************************
   // Command codes and register fields
   // *****************************************************************
   localparam logic [7:0] cmd_unlock         = 8'hF2;
   localparam logic [3:0] cmd_seek_nibble    = 4'h7;
   localparam int         lba_select_bit     = 6;
   localparam int         identifier_bit     = 0;
   localparam int         words_per_sector   = 256;
   localparam int         first_pw_word      = 1;
   localparam int         last_pw_word       = 16;
   localparam logic [2:0] attempts_reset     = 3'h5;
   localparam int         seek_time_cycles   = 8;

   // Error flag positions.
   localparam int err_uncorrectable = 6;
   localparam int err_target_nf     = 4;
   localparam int err_aborted       = 2;
   // Status flag positions.
   localparam int st_busy           = 7;
   localparam int st_ready          = 6;
   localparam int st_seek_complete  = 4;
   localparam int st_data_request   = 3;
   localparam int st_error          = 0;

   // *****************************************************************
   // Controller registers over APB (byte addresses)
   // *****************************************************************
   localparam logic [7:0] reg_command  = 8'h00;
   localparam logic [7:0] reg_taskfile = 8'h04;
   localparam logic [7:0] reg_data     = 8'h08;
   localparam logic [7:0] reg_result   = 8'h0C;
   localparam logic [7:0] reg_address  = 8'h10;
   localparam logic [7:0] reg_irq_stat = 8'h14;
   localparam logic [7:0] reg_irq_mask = 8'h18;
   localparam logic [1:0] irq_done     = 2'h1;
   localparam logic [1:0] irq_drq      = 2'h2;

endpackage : unlock_seek_pkg

// file: taskfile_if.sv
// Task-file link between the host controller and the drive end.
// Assumes both ends share pclk and presetn.
`timescale 1ns/100ps
`default_nettype none
interface taskfile_if;
   logic [7:0]  command;
   logic        command_strobe;
   logic [7:0]  sector_number;
   logic [7:0]  cylinder_low;
   logic [7:0]  cylinder_high;
   logic [7:0]  device_head;
   logic [15:0] data_word;
   logic        data_strobe;
   logic [7:0]  command_error_flags;
   logic [7:0]  command_status_flags;
   logic [7:0]  ret_sector_number;
   logic [7:0]  ret_cylinder_low;
   logic [7:0]  ret_cylinder_high;
   logic [3:0]  ret_head;

   modport host (output command, command_strobe, sector_number, cylinder_low,
                 cylinder_high, device_head, data_word, data_strobe,
                 input command_error_flags, command_status_flags,
                 ret_sector_number, ret_cylinder_low, ret_cylinder_high, ret_head);
   modport device (input command, command_strobe, sector_number, cylinder_low,
                   cylinder_high, device_head, data_word, data_strobe,
                   output command_error_flags, command_status_flags,
                   ret_sector_number, ret_cylinder_low, ret_cylinder_high, ret_head);
endinterface : taskfile_if
`default_nettype wire

// file: drive_security_seek.sv
// Drive end: unlock command with password check, and seek command.
// Assumes the host writes one word per data_strobe while data request is shown.
`timescale 1ns/100ps
`default_nettype none
module drive_security_seek
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Task-file link.
   taskfile_if.device       tf,
   // Stored security settings.
   input  wire logic        security_enabled,
   input  wire logic        level_maximum,
   input  wire logic [15:0] master_password [16],
   input  wire logic [15:0] user_password [16],
   // Drive state.
   output logic             locked,
   output logic [2:0]       attempts_left,
   output logic [27:0]      current_address
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [1:0] {idle, receive, seeking} phase_type;

   typedef struct packed {
      phase_type   phase;
      logic        locked;
      logic [2:0]  attempts;
      logic [8:0]  word_count;
      logic        use_master;
      logic        mismatch;
      logic [3:0]  seek_timer;
      logic [27:0] address;
      logic [7:0]  error_flags;
      logic [7:0]  status_flags;
   } state_type;

   localparam int st_busy          = unlock_seek_pkg::st_busy;
   localparam int st_seek_complete = unlock_seek_pkg::st_seek_complete;
   localparam int st_data_request  = unlock_seek_pkg::st_data_request;
   localparam int st_error         = unlock_seek_pkg::st_error;

   state_type state;
   state_type next_state;
   logic      pw_equal;

   always_comb
   begin
      logic [15:0] expect_word;
      expect_word = 16'h0000;
      next_state = state;
      pw_equal = 1'b0;
      unique case (state.phase)
         idle:
         begin
            if (tf.command_strobe)
            begin
               next_state.error_flags = 8'h00;
               next_state.status_flags[st_error] = 1'b0;
               if (tf.command == unlock_seek_pkg::cmd_unlock)
               begin
                  // Reject before any data so the host sees a pre-sector abort.
                  if (state.attempts == 3'h0)
                  begin
                     next_state.error_flags[unlock_seek_pkg::err_aborted] = 1'b1;
                     next_state.status_flags[st_error] = 1'b1;
                  end
                  else
                  begin
                     next_state.phase = receive;
                     next_state.word_count = 9'h000;
                     next_state.mismatch = 1'b0;
                     next_state.status_flags[st_busy] = 1'b0;
                     next_state.status_flags[st_data_request] = 1'b1;
                  end
               end
               else if (tf.command[7:4] == unlock_seek_pkg::cmd_seek_nibble)
               begin
                  next_state.phase = seeking;
                  next_state.seek_timer = 4'h0;
                  next_state.status_flags[st_busy] = 1'b1;
                  next_state.status_flags[st_seek_complete] = 1'b0;
                  if (tf.device_head[unlock_seek_pkg::lba_select_bit])
                     next_state.address = {tf.device_head[3:0], tf.cylinder_high,
                                           tf.cylinder_low, tf.sector_number};
                  else
                     next_state.address = {tf.device_head[3:0], tf.cylinder_high,
                                           tf.cylinder_low, 8'h00};
               end
               else
               begin
                  next_state.error_flags[unlock_seek_pkg::err_aborted] = 1'b1;
                  next_state.status_flags[st_error] = 1'b1;
               end
            end
         end
         receive:
         begin
            if (tf.data_strobe)
            begin
               if (state.word_count == 9'h000)
                  next_state.use_master = tf.data_word[unlock_seek_pkg::identifier_bit];
               else if (state.word_count <= 9'(unlock_seek_pkg::last_pw_word))
               begin
                  expect_word = state.use_master ? master_password[state.word_count[3:0] - 4'h1]
                                                 : user_password[state.word_count[3:0] - 4'h1];
                  if (tf.data_word != expect_word)
                     next_state.mismatch = 1'b1;
               end
               next_state.word_count = state.word_count + 9'h001;
               if (state.word_count == 9'(unlock_seek_pkg::words_per_sector - 1))
               begin
                  next_state.phase = idle;
                  next_state.status_flags[st_data_request] = 1'b0;
                  pw_equal = !state.mismatch;
                  if (!state.use_master && !security_enabled)
                  begin
                     next_state.error_flags[unlock_seek_pkg::err_aborted] = 1'b1;
                     next_state.status_flags[st_error] = 1'b1;
                  end
                  else if (state.use_master && level_maximum)
                  begin
                     next_state.error_flags[unlock_seek_pkg::err_aborted] = 1'b1;
                     next_state.status_flags[st_error] = 1'b1;
                  end
                  else if (pw_equal)
                     next_state.locked = 1'b0;
                  else
                  begin
                     // Only a mismatch costs an attempt once the sector is in.
                     next_state.error_flags[unlock_seek_pkg::err_aborted] = 1'b1;
                     next_state.status_flags[st_error] = 1'b1;
                     next_state.attempts = state.attempts - 3'h1;
                  end
               end
            end
         end
         seeking:
         begin
            next_state.seek_timer = state.seek_timer + 4'h1;
            if (state.seek_timer == 4'(unlock_seek_pkg::seek_time_cycles - 1))
            begin
               next_state.phase = idle;
               next_state.status_flags[st_busy] = 1'b0;
               next_state.status_flags[st_seek_complete] = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state.phase <= idle;
         state.locked <= 1'b1;
         state.attempts <= unlock_seek_pkg::attempts_reset;
         state.word_count <= 9'h000;
         state.use_master <= 1'b0;
         state.mismatch <= 1'b0;
         state.seek_timer <= 4'h0;
         state.address <= 28'h0000000;
         state.error_flags <= 8'h00;
         state.status_flags <= 8'h40;
      end
      else
         state <= next_state;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign tf.command_error_flags  = state.error_flags;
   assign tf.command_status_flags = state.status_flags;
   assign tf.ret_sector_number    = state.address[7:0];
   assign tf.ret_cylinder_low     = state.address[15:8];
   assign tf.ret_cylinder_high    = state.address[23:16];
   assign tf.ret_head             = state.address[27:24];
   assign locked                  = state.locked;
   assign attempts_left           = state.attempts;
   assign current_address         = state.address;

endmodule : drive_security_seek
`default_nettype wire

// file: host_taskfile_ctrl.sv
// Host end: APB registers that issue task-file commands and feed data words.
// Assumes a drive end on the same clock behind taskfile_if.
`timescale 1ns/100ps
`default_nettype none
module host_taskfile_ctrl
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt.
   output logic             irq,
   // Task-file link.
   taskfile_if.host         tf
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  command;
      logic        command_strobe;
      logic [31:0] taskfile;
      logic [15:0] data_word;
      logic        data_strobe;
      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        irq;
      logic        busy_seen;
      logic        drq_seen;
   } state_type;

   state_type state;
   state_type next_state;

   always_comb
   begin
      logic access;
      logic [1:0] events;
      access = psel && !penable;
      events = 2'h0;
      next_state = state;
      next_state.command_strobe = 1'b0;
      next_state.data_strobe = 1'b0;
      next_state.ready = 1'b0;
      next_state.slverr = 1'b0;
      next_state.busy_seen = tf.command_status_flags[unlock_seek_pkg::st_busy]
                             || tf.command_status_flags[unlock_seek_pkg::st_data_request];
      next_state.drq_seen = tf.command_status_flags[unlock_seek_pkg::st_data_request];
      if (state.busy_seen && !next_state.busy_seen)
         events = events | unlock_seek_pkg::irq_done;
      if (!state.drq_seen && next_state.drq_seen)
         events = events | unlock_seek_pkg::irq_drq;
      if (access)
      begin
         next_state.ready = 1'b1;
         next_state.rdata = 32'h00000000;
         unique case (paddr)
            unlock_seek_pkg::reg_command:
               if (pwrite)
               begin
                  next_state.command = pwdata[7:0];
                  next_state.command_strobe = 1'b1;
               end
               else
                  next_state.rdata = {24'h000000, state.command};
            unlock_seek_pkg::reg_taskfile:
               if (pwrite)
                  next_state.taskfile = pwdata;
               else
                  next_state.rdata = state.taskfile;
            unlock_seek_pkg::reg_data:
               if (pwrite)
               begin
                  next_state.data_word = pwdata[15:0];
                  next_state.data_strobe = 1'b1;
               end
            unlock_seek_pkg::reg_result:
               next_state.rdata = {16'h0000, tf.command_error_flags,
                                   tf.command_status_flags};
            unlock_seek_pkg::reg_address:
               next_state.rdata = {4'h0, tf.ret_head, tf.ret_cylinder_high,
                                   tf.ret_cylinder_low, tf.ret_sector_number};
            unlock_seek_pkg::reg_irq_stat:
               if (pwrite)
                  next_state.irq_status = state.irq_status & ~pwdata[1:0];
               else
                  next_state.rdata = {30'h00000000, state.irq_status};
            unlock_seek_pkg::reg_irq_mask:
               if (pwrite)
                  next_state.irq_mask = pwdata[1:0];
               else
                  next_state.rdata = {30'h00000000, state.irq_mask};
            default:
               next_state.slverr = 1'b1;
         endcase
      end
      // New events win over a clear in the same cycle.
      next_state.irq_status = next_state.irq_status | events;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata            = state.rdata;
   assign pready            = state.ready;
   assign pslverr           = state.slverr;
   assign irq               = state.irq;
   assign tf.command        = state.command;
   assign tf.command_strobe = state.command_strobe;
   assign tf.sector_number  = state.taskfile[7:0];
   assign tf.cylinder_low   = state.taskfile[15:8];
   assign tf.cylinder_high  = state.taskfile[23:16];
   assign tf.device_head    = state.taskfile[31:24];
   assign tf.data_word      = state.data_word;
   assign tf.data_strobe    = state.data_strobe;

endmodule : host_taskfile_ctrl
`default_nettype wire

// file: security_unlock_and_seek_cmd_properties.sv
// Concurrent checks on the task-file link between the host and drive ends.
// Assumes it is instantiated beside the taskfile_if that joins the two ends.
`timescale 1ns/100ps
`default_nettype none
module security_unlock_and_seek_cmd_checker
(
   // Clock and reset.
   input wire logic       pclk,
   input wire logic       presetn,
   // Host side of the link.
   input wire logic [7:0] command,
   input wire logic       command_strobe,
   input wire logic [7:0] sector_number,
   input wire logic [7:0] cylinder_low,
   input wire logic [7:0] cylinder_high,
   input wire logic [7:0] device_head,
   input wire logic       data_strobe,
   // Drive side of the link.
   input wire logic [7:0] command_error_flags,
   input wire logic [7:0] command_status_flags,
   input wire logic [7:0] ret_sector_number,
   input wire logic [7:0] ret_cylinder_low,
   input wire logic [7:0] ret_cylinder_high,
   input wire logic [3:0] ret_head
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       busy = command_status_flags[unlock_seek_pkg::st_busy];
   wire       drq  = command_status_flags[unlock_seek_pkg::st_data_request];
   wire       seek_complete_flag  = command_status_flags[unlock_seek_pkg::st_seek_complete];
   wire       fail = command_status_flags[unlock_seek_pkg::st_error];
   logic [8:0] words;
   // *****************************************************************
   // Words taken since the last command
   // *****************************************************************
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         words <= 9'h000;
      else if (command_strobe)
         words <= 9'h000;
      else if (data_strobe && drq)
         words <= words + 9'h001;
   sequence seek_start;
      command_strobe && command[7:4] == unlock_seek_pkg::cmd_seek_nibble && !busy && !drq;
   endsequence
   sequence seek_run;
      busy[*8] ##1 (!busy && seek_complete_flag);
   endsequence
   unlock_start_a: assert property (command_strobe && command == unlock_seek_pkg::cmd_unlock
      && !busy && !drq |=> drq || command_error_flags[2]) else $error("unlock not answered");
   sector_count_a: assert property ($fell(drq) |-> words == 9'h100)
      else $error("sector not 256 words");
   abort_only_a: assert property ($fell(drq) && fail |-> command_error_flags == 8'h04)
      else $error("late error not a plain abort");
   error_status_a: assert property (!busy |-> fail == (command_error_flags != 8'h00))
      else $error("error bit disagrees with flags");
   seek_timing_a: assert property (seek_start |=> seek_run)
      else $error("seek timing wrong");
   seek_clean_a: assert property ($rose(seek_complete_flag) |-> command_error_flags == 8'h00)
      else $error("seek ended with error");
   lba_return_a: assert property ($rose(seek_complete_flag) && device_head[6] |->
      {ret_head, ret_cylinder_high, ret_cylinder_low, ret_sector_number}
      == {device_head[3:0], cylinder_high, cylinder_low, sector_number}) else $error("lba return");
   chs_return_a: assert property ($rose(seek_complete_flag) && !device_head[6] |->
      {ret_head, ret_cylinder_high, ret_cylinder_low, ret_sector_number}
      == {device_head[3:0], cylinder_high, cylinder_low, 8'h00}) else $error("chs return");
endmodule : security_unlock_and_seek_cmd_checker
`default_nettype wire

// file: security_unlock_and_seek_cmd_test.sv
// Testbench joining host and drive ends over APB and the task-file link.
// Assumes the package, interface and both design modules are compiled first.
`timescale 1ns/100ps
`default_nettype none
module security_unlock_and_seek_cmd_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, serr, d, locked;
   logic        sec_en = 1'b1;
   logic        lvl_max = 1'b0;
   logic [15:0] mpw [16];
   logic [15:0] upw [16];
   logic [2:0]  attempts;
   logic [27:0] cur;
   int          fails = 0;
   int          n_checks = 0;
   localparam int aborted_command_flag = 8 + unlock_seek_pkg::err_aborted;
   taskfile_if tf ();
   always #25 pclk = ~pclk;
   host_taskfile_ctrl i_host_taskfile_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .tf(tf));
   drive_security_seek i_drive_security_seek (.pclk(pclk), .presetn(presetn), .tf(tf),
      .security_enabled(sec_en), .level_maximum(lvl_max), .master_password(mpw),
      .user_password(upw), .locked(locked), .attempts_left(attempts), .current_address(cur));
   security_unlock_and_seek_cmd_checker i_security_unlock_and_seek_cmd_checker (.pclk(pclk),
      .presetn(presetn), .command(tf.command), .command_strobe(tf.command_strobe),
      .sector_number(tf.sector_number), .cylinder_low(tf.cylinder_low),
      .cylinder_high(tf.cylinder_high), .device_head(tf.device_head),
      .data_strobe(tf.data_strobe), .command_error_flags(tf.command_error_flags),
      .command_status_flags(tf.command_status_flags), .ret_sector_number(tf.ret_sector_number),
      .ret_cylinder_low(tf.ret_cylinder_low), .ret_cylinder_high(tf.ret_cylinder_high),
      .ret_head(tf.ret_head));
   task close_out;
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk
   // One APB transfer; read data and error are taken at the pready edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16)
      begin
         fails++;
         close_out();
      end
   endtask : apb
   task wait_st(input int idx, input logic v, input int n, output logic ok);
      ok = 1'b0;
      repeat (n)
      begin
         @(posedge pclk);
         if (tf.command_status_flags[idx] === v)
         begin
            ok = 1'b1;
            break;
         end
      end
   endtask : wait_st
   task do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   function automatic logic [31:0] word(input logic m, input logic [15:0] f, input int i);
      if (i == 0)
         return {31'h0, m};
      if (i > 16)
         return 32'h0;
      return {16'h0, (m ? mpw[i-1] : upw[i-1]) ^ (i == 1 ? f : 16'h0000)};
   endfunction : word
   // Unlock with the master or user password, first password word flipped by f; result lands in rd.
   task unlock(input logic m, input logic [15:0] f, output logic got);
      logic ok;
      apb(1'b1, unlock_seek_pkg::reg_command, 32'h000000F2);
      wait_st(unlock_seek_pkg::st_data_request, 1'b1, 6, got);
      if (got)
      begin
         for (int i = 0; i < 256; i++)
            apb(1'b1, unlock_seek_pkg::reg_data, word(m, f, i));
         wait_st(unlock_seek_pkg::st_data_request, 1'b0, 10, ok);
         chk("data request drop", 32'h1, 32'(ok));
      end
      apb(1'b0, unlock_seek_pkg::reg_result, 32'h0);
   endtask : unlock
   task t_user;
      chk("locked", 32'h1, 32'(locked));
      chk("attempts", 32'h5, 32'(attempts));
      unlock(1'b0, 16'h0000, d);
      chk("data request", 32'h1, 32'(d));
      chk("abort", 32'h0, 32'(rd[aborted_command_flag]));
      chk("locked", 32'h0, 32'(locked));
      do_reset;
      chk("locked", 32'h1, 32'(locked));
      unlock(1'b0, 16'h0000, d);
      chk("locked", 32'h0, 32'(locked));
   endtask : t_user
   task t_master;
      do_reset;
      unlock(1'b1, 16'h0001, d);
      chk("abort", 32'h1, 32'(rd[aborted_command_flag]));
      chk("attempts", 32'h4, 32'(attempts));
      unlock(1'b1, 16'h0000, d);
      chk("locked", 32'h0, 32'(locked));
      do_reset;
      lvl_max <= 1'b1;
      unlock(1'b1, 16'h0000, d);
      chk("abort", 32'h1, 32'(rd[aborted_command_flag]));
      chk("locked", 32'h1, 32'(locked));
      lvl_max <= 1'b0;
   endtask : t_master
   task t_disabled;
      do_reset;
      sec_en <= 1'b0;
      unlock(1'b0, 16'h0000, d);
      chk("abort", 32'h1, 32'(rd[aborted_command_flag]));
      sec_en <= 1'b1;
   endtask : t_disabled
   task t_exhaust;
      do_reset;
      for (int i = 4; i >= 0; i--)
      begin
         unlock(1'b0, 16'h8000, d);
         chk("attempts", 32'(i), 32'(attempts));
      end
      unlock(1'b0, 16'h0000, d);
      chk("data request", 32'h0, 32'(d));
      chk("abort", 32'h1, 32'(rd[aborted_command_flag]));
      chk("locked", 32'h1, 32'(locked));
      chk("attempts", 32'h0, 32'(attempts));
      do_reset;
      chk("attempts", 32'h5, 32'(attempts));
   endtask : t_exhaust
   task run_seek(input logic [31:0] regs, input logic [7:0] code, input logic [27:0] exp);
      logic ok;
      apb(1'b1, unlock_seek_pkg::reg_taskfile, regs);
      apb(1'b1, unlock_seek_pkg::reg_command, {24'h0, code});
      wait_st(unlock_seek_pkg::st_busy, 1'b1, 6, ok);
      chk("seek busy", 32'h1, 32'(ok));
      wait_st(unlock_seek_pkg::st_busy, 1'b0, 20, ok);
      chk("seek done", 32'h1, 32'(ok));
      apb(1'b0, unlock_seek_pkg::reg_address, 32'h0);
      chk("address", 32'(exp), 32'(rd[27:0]));
      apb(1'b0, unlock_seek_pkg::reg_result, 32'h0);
      chk("seek result", 32'h0010, 32'(rd[15:0] & 16'hFF11));
   endtask : run_seek
   task t_seek;
      run_seek(32'hEA563412, 8'h70, 28'hA563412);
      chk("current", 32'h0A563412, 32'(cur));
      run_seek(32'hA3020177, 8'h7F, 28'h3020100);
      apb(1'b1, unlock_seek_pkg::reg_command, 32'h00000020);
      apb(1'b0, unlock_seek_pkg::reg_result, 32'h0);
      chk("unknown command abort", 32'h1, 32'(rd[aborted_command_flag]));
   endtask : t_seek
   task t_irq;
      logic a;
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, 32'(serr));
      apb(1'b0, unlock_seek_pkg::reg_irq_stat, 32'h0);
      chk("done event", 32'h1, 32'(rd[0]));
      apb(1'b1, unlock_seek_pkg::reg_irq_mask, 32'h0);
      apb(1'b0, unlock_seek_pkg::reg_irq_stat, 32'h0);
      a = irq;
      apb(1'b1, unlock_seek_pkg::reg_irq_mask, 32'h3);
      apb(1'b0, unlock_seek_pkg::reg_irq_stat, 32'h0);
      chk("irq masked", 32'h0, 32'(a));
      chk("irq unmasked", 32'h1, 32'(irq));
      apb(1'b1, unlock_seek_pkg::reg_irq_stat, 32'h3);
      apb(1'b0, unlock_seek_pkg::reg_irq_stat, 32'h0);
      chk("cleared", 32'h0, 32'(rd[1:0]));
      chk("irq low", 32'h0, 32'(irq));
   endtask : t_irq
   initial
   begin
      for (int i = 0; i < 16; i++)
      begin
         mpw[i] <= 16'hA000 + 16'(i);
         upw[i] <= 16'h5000 + 16'(i);
      end
      do_reset;
      t_user();
      t_master();
      t_disabled();
      t_exhaust();
      t_seek();
      t_irq();
      close_out();
   end
endmodule : security_unlock_and_seek_cmd_test
`default_nettype wire
